// ---- design/bom_datapath.sv ----
// OR/move execution datapath: accumulator, zero flag and file writes
// What this block does
// - OR-immediate ORs accumulator with 8-bit literal, result to accumulator, zero updated.
// - Load-immediate puts literal in accumulator, flags untouched.
// - OR-with-register ORs accumulator and file register, result by destination bit.
// - Store-accumulator copies accumulator to file register, flags untouched.
// - Copy-register moves file register to accumulator, or rewrites it unchanged.
// - Copy-register updates zero flag for both destinations.
`timescale 1ns/1ps
`default_nettype none
module bom_datapath
    import bom_pkg::*;
#(
    parameter int DEPTH = FILE_DEPTH
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic clkEn,
    // Instruction issue, one per enabled cycle while valid
    input wire logic opValid,
    input wire bom_op_t opCode,
    input wire logic [7:0] literal,
    input wire logic [ADDR_W-1:0] fileAddr,
    input wire logic destSel,
    // Architectural state
    output logic [7:0] accum,
    output logic zeroFlag,
    // Observation of the file write this cycle
    output logic fileWrEn,
    output logic [7:0] fileRdData
);
    // Refuse a file larger than the address can reach
    if (DEPTH > FILE_DEPTH || DEPTH < 1) begin : gBadDepth
        $error("bom_datapath: depth out of range");
    end

    logic [7:0] accum_reg;
    logic [7:0] accum_next;
    logic zero_reg;
    logic zero_next;

    // Decode; an invalid or unknown code acts as idle
    // so a stray code can never write the file or move a flag
    wire isOrImm = opValid && (opCode == BOM_OR_IMMEDIATE_OP);
    wire isLoadImm = opValid && (opCode == BOM_LOAD_IMMEDIATE_OP);
    wire isOrReg = opValid && (opCode == BOM_OR_WITH_REGISTER_OP);
    wire isStore = opValid && (opCode == BOM_STORE_ACCUM_OP);
    wire isCopy = opValid && (opCode == BOM_COPY_REGISTER_OP);

    // Result selection
    wire [7:0] orImmRes = accum_reg | literal;
    wire [7:0] orRegRes = accum_reg | fileRdData;
    wire [7:0] aluRes = isOrImm ? orImmRes : (isOrReg ? orRegRes : fileRdData);
    wire resZero = (aluRes == BYTE_ZERO);
    wire touchZero = isOrImm || isOrReg || isCopy;

    // File write: store always, OR-with-register and copy only with file destination.
    // Read and write share one address; the write is clocked, so an OR or
    // copy back into the same register reads the old byte with no loop.
    assign fileWrEn = clkEn && (isStore || ((isOrReg || isCopy) && destSel == DEST_FILE));
    wire [7:0] fileWrData = isStore ? accum_reg : aluRes;

    // Accumulator next value
    // Priority order is moot: at most one decode line is high
    always_comb begin
        accum_next = accum_reg;
        if (isLoadImm) begin
            accum_next = literal;
        end else if (isOrImm) begin
            accum_next = orImmRes;
        end else if ((isOrReg || isCopy) && destSel == DEST_ACC) begin
            accum_next = aluRes;
        end
    end

    // Zero flag only moves for OR and copy instructions
    // Load and store leave the flag, so the old value is held
    assign zero_next = touchZero ? resZero : zero_reg;

    // State update, frozen while the enable is low
    // Reset wins over the enable so a frozen core still comes up clean
    always_ff @(posedge mclk) begin
        if (srst) begin
            accum_reg <= ACC_RESET;
            zero_reg <= ZERO_RESET;
        end else if (clkEn) begin
            accum_reg <= accum_next;
            zero_reg <= zero_next;
        end
    end

    assign accum = accum_reg;
    assign zeroFlag = zero_reg;

    bom_file_regs #(
        .DEPTH(DEPTH),
        .AW(ADDR_W)
    ) uFile (
        .mclk(mclk),
        .clkEn(clkEn),
        .wrEn(fileWrEn),
        .wrAddr(fileAddr),
        .wrData(fileWrData),
        .rdAddr(fileAddr),
        .rdData(fileRdData)
    );

    // Checks, in the cycle an instruction is taken or one edge after; reset masks them all.
    // File checks read back through the same address in the next cycle.

    // OR-immediate result lands in the accumulator
    orImm_acc_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isOrImm
        |=> accum == ($past(accum) | $past(literal)))
        else $error("or-immediate result wrong");

    // OR-immediate zero flag follows its result
    orImm_zero_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isOrImm
        |=> zeroFlag == (accum == 8'h00))
        else $error("or-immediate zero flag wrong");

    // OR-immediate ignores the destination bit
    orImm_nowr_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isOrImm
        |-> !fileWrEn)
        else $error("or-immediate wrote the file");

    // Load-immediate sets the accumulator, flag untouched
    loadImm_val_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isLoadImm
        |=> accum == $past(literal) && $stable(zeroFlag))
        else $error("load-immediate wrong");

    // Load-immediate never touches the file
    loadImm_nowr_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isLoadImm
        |-> !fileWrEn)
        else $error("load-immediate wrote the file");

    // OR-with-register to the file leaves the accumulator
    orReg_dest_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isOrReg && destSel
        |-> fileWrEn ##1 $stable(accum))
        else $error("or-register file destination wrong");

    // OR-with-register to the file stores the OR of both operands
    orReg_wdata_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isOrReg && destSel ##1 (fileAddr == $past(fileAddr))
        |-> fileRdData == ($past(accum) | $past(fileRdData)))
        else $error("or-register file data wrong");

    // OR-with-register to the accumulator
    orReg_acc_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isOrReg && !destSel |-> !fileWrEn ##1
        accum == ($past(accum) | $past(fileRdData)))
        else $error("or-register accumulator destination wrong");

    // OR-with-register to the file: flag follows the written byte
    orReg_fzero_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isOrReg && destSel ##1 (fileAddr == $past(fileAddr))
        |-> zeroFlag == (fileRdData == BYTE_ZERO))
        else $error("or-register file zero flag wrong");

    // Store writes the file and nothing else
    store_keep_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isStore
        |-> fileWrEn ##1 $stable(zeroFlag) && $stable(accum))
        else $error("store changed flags or accumulator");

    // Store puts the accumulator byte in the register
    store_data_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isStore ##1 (fileAddr == $past(fileAddr))
        |-> fileRdData == $past(accum))
        else $error("store data wrong");

    // Copy to the accumulator
    copy_move_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isCopy && !destSel
        |=> accum == $past(fileRdData))
        else $error("copy to accumulator wrong");

    // Copy to the accumulator does not write the file
    copy_dest_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isCopy && !destSel
        |-> !fileWrEn)
        else $error("copy to accumulator wrote the file");

    // Copy back to the file keeps the byte and the accumulator
    copy_rewrite_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isCopy && destSel ##1 (fileAddr == $past(fileAddr))
        |-> fileRdData == $past(fileRdData) && $stable(accum))
        else $error("copy to file changed data");

    // Copy moves the zero flag for either destination
    copy_zero_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && isCopy
        |=> zeroFlag == ($past(fileRdData) == 8'h00))
        else $error("copy zero flag wrong");

    // Register sources into the accumulator: flag matches it
    zero_truth_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && (isOrReg || isCopy) && !destSel
        |=> zeroFlag == (accum == BYTE_ZERO))
        else $error("zero flag disagrees with accumulator");

    // A code outside the five instructions changes nothing
    unknown_code_a: assert property (@(posedge mclk) disable iff (srst)
        clkEn && opValid && !(opCode inside {BOM_OR_IMMEDIATE_OP, BOM_LOAD_IMMEDIATE_OP,
            BOM_OR_WITH_REGISTER_OP, BOM_STORE_ACCUM_OP, BOM_COPY_REGISTER_OP})
        |-> !fileWrEn ##1 $stable(accum) && $stable(zeroFlag))
        else $error("unknown code changed state");

    // Idle, no instruction or enable low changes nothing
    idle_hold_a: assert property (@(posedge mclk) disable iff (srst)
        (!clkEn || !opValid || opCode == BOM_IDLE_OP) |-> !fileWrEn ##1
        $stable(accum) && $stable(zeroFlag))
        else $error("idle changed state");

    // Main scenarios reached
    orImm_run_c: cover property (@(posedge mclk) clkEn && isOrImm);
    copy_test_c: cover property (@(posedge mclk) clkEn && isCopy && destSel);
    store_run_c: cover property (@(posedge mclk) clkEn && isStore ##1 clkEn && isCopy);
    zero_set_c: cover property (@(posedge mclk) !zeroFlag ##1 zeroFlag);
    orReg_file_c: cover property (@(posedge mclk) clkEn && isOrReg && destSel);
endmodule
`default_nettype wire

// ---- shared/bom_pkg.sv ----
// Constants and types shared by the OR/move datapath
package bom_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // One-hot operation codes presented on the op input
    typedef enum logic [5:0] {
        BOM_IDLE_OP = 6'h01,
        BOM_OR_IMMEDIATE_OP = 6'h02,
        BOM_LOAD_IMMEDIATE_OP = 6'h04,
        BOM_OR_WITH_REGISTER_OP = 6'h08,
        BOM_STORE_ACCUM_OP = 6'h10,
        BOM_COPY_REGISTER_OP = 6'h20
    } bom_op_t;
endpackage

// ---- design/bom_file_regs.sv ----
// File register array: one synchronous write port, one async read port
`timescale 1ns/1ps
`default_nettype none
module bom_file_regs
    import bom_pkg::*;
#(
    parameter int DEPTH = FILE_DEPTH,
    parameter int AW = ADDR_W
) (
    // Clock and control
    input wire logic mclk,
    input wire logic clkEn,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [7:0] wrData,
    // Read port
    input wire logic [AW-1:0] rdAddr,
    output logic [7:0] rdData
);
    // Refuse a depth that the address cannot reach
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : gBadDepth
        $error("bom_file_regs: depth does not fit address width");
    end

    logic [7:0] memArr [0:DEPTH-1];

    // Contents are not reset, as in a plain RAM
    always_ff @(posedge mclk) begin
        if (clkEn && wrEn) begin
            memArr[wrAddr] <= wrData;
        end
    end

    // Combinational read so the datapath can finish in one cycle
    assign rdData = memArr[rdAddr];
endmodule
`default_nettype wire

// ---- tb/bom_datapath_tb_top.sv ----
// Self-checking bench for the OR/move datapath
`timescale 1ns/1ps
`default_nettype none
module bom_datapath_tb_top;
    import bom_pkg::*;
    // Stimulus and observed ports
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    logic opValid = 1'b0;
    bom_op_t opCode = BOM_IDLE_OP;
    logic [7:0] literal = 8'h00;
    logic [6:0] fileAddr = 7'h00;
    logic destSel = 1'b0;
    logic [7:0] accum;
    logic zeroFlag;
    logic fileWrEn;
    logic [7:0] fileRdData;
    // Reference state; file bytes stay X until stored, so only written ones are read
    logic [7:0] eAcc;
    logic eZero;
    logic [7:0] mem [128];
    int n_mismatch = 0;
    int check_count = 0;
    bom_datapath u_dut (.mclk(mclk), .srst(srst), .clkEn(clkEn), .opValid(opValid),
        .opCode(opCode), .literal(literal), .fileAddr(fileAddr), .destSel(destSel),
        .accum(accum), .zeroFlag(zeroFlag), .fileWrEn(fileWrEn), .fileRdData(fileRdData));
    // 200 MHz clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: flag got %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One instruction, then a dead cycle; judged against the reference state
    task automatic ex(input bom_op_t op, input logic [7:0] k, input logic [6:0] a,
            input logic d, input logic v = 1'b1, input logic e = 1'b1);
        logic [7:0] r;
        logic w;
        w = 1'b0;
        r = (op == BOM_COPY_REGISTER_OP) ? mem[a] : (eAcc | (op[1] ? k : mem[a]));
        @(posedge mclk);
        opValid <= v;
        clkEn <= e;
        opCode <= op;
        literal <= k;
        fileAddr <= a;
        destSel <= d;
        if (v && e) begin
            case (op)
                BOM_LOAD_IMMEDIATE_OP: eAcc = k;
                BOM_STORE_ACCUM_OP: {w, mem[a]} = {1'b1, eAcc};
                BOM_OR_IMMEDIATE_OP, BOM_OR_WITH_REGISTER_OP, BOM_COPY_REGISTER_OP: begin
                    w = d && !op[1];
                    if (w) mem[a] = r;
                    else eAcc = r;
                    eZero = (r == BYTE_ZERO);
                end
                default: ;
            endcase
        end
        #1;
        chk_flag(fileWrEn, w);
        @(posedge mclk);
        opValid <= 1'b0;
        clkEn <= 1'b1;
        #1;
        chk(accum, eAcc);
        chk_flag(zeroFlag, eZero);
        if (w || op == BOM_STORE_ACCUM_OP) chk(fileRdData, mem[a]);
    endtask
    task automatic t_imm();
        ex(BOM_LOAD_IMMEDIATE_OP, 8'h00, 7'h00, 1'b0);
        ex(BOM_OR_IMMEDIATE_OP, 8'h00, 7'h00, 1'b0);
        ex(BOM_LOAD_IMMEDIATE_OP, 8'hA5, 7'h00, 1'b0);
        ex(BOM_OR_IMMEDIATE_OP, 8'h5A, 7'h00, 1'b0);
        ex(BOM_LOAD_IMMEDIATE_OP, 8'h00, 7'h00, 1'b0);
        ex(BOM_OR_IMMEDIATE_OP, 8'hFF, 7'h00, 1'b0);
    endtask
    task automatic t_file();
        ex(BOM_LOAD_IMMEDIATE_OP, 8'h0F, 7'h00, 1'b0);
        ex(BOM_STORE_ACCUM_OP, 8'h00, 7'h7F, 1'b0);
        ex(BOM_LOAD_IMMEDIATE_OP, 8'h00, 7'h00, 1'b0);
        ex(BOM_OR_IMMEDIATE_OP, 8'h00, 7'h00, 1'b0);
        ex(BOM_STORE_ACCUM_OP, 8'h00, 7'h00, 1'b1);
        ex(BOM_LOAD_IMMEDIATE_OP, 8'hF0, 7'h00, 1'b0);
        ex(BOM_OR_WITH_REGISTER_OP, 8'h00, 7'h7F, 1'b0);
        ex(BOM_LOAD_IMMEDIATE_OP, 8'h00, 7'h00, 1'b0);
        ex(BOM_OR_WITH_REGISTER_OP, 8'h00, 7'h7F, 1'b1);
        ex(BOM_OR_WITH_REGISTER_OP, 8'h00, 7'h00, 1'b1);
        ex(BOM_COPY_REGISTER_OP, 8'h00, 7'h7F, 1'b1);
        ex(BOM_COPY_REGISTER_OP, 8'h00, 7'h00, 1'b1);
        ex(BOM_COPY_REGISTER_OP, 8'h00, 7'h7F, 1'b0);
        ex(BOM_COPY_REGISTER_OP, 8'h00, 7'h00, 1'b0);
    endtask
    // Accum is 00 and file 7F holds 0F, so any stray store would show
    task automatic t_gate();
        ex(BOM_IDLE_OP, 8'hFF, 7'h7F, 1'b1);
        ex(BOM_STORE_ACCUM_OP, 8'hFF, 7'h7F, 1'b0, 1'b0);
        ex(BOM_STORE_ACCUM_OP, 8'hFF, 7'h7F, 1'b0, 1'b1, 1'b0);
        ex(bom_op_t'(6'h03), 8'hFF, 7'h7F, 1'b1);
        ex(BOM_COPY_REGISTER_OP, 8'h00, 7'h7F, 1'b0);
    endtask
    // Reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        eAcc = ACC_RESET;
        eZero = ZERO_RESET;
        chk(accum, eAcc);
        chk_flag(zeroFlag, eZero);
        t_imm();
        t_file();
        t_gate();
        wrap_up();
    end
endmodule
`default_nettype wire
